// *** src/bdp_dimming_core.sv ***
/*
 * Backlight dimming core: brightness code, chopping PWM, current target,
 * buck gate timing, lamp-out and buck-short fault latches, AXI4-Lite registers.
 * Assumes analog levels arrive already digitized and all pins are synchronous
 * to clk; the mode clock and buck sync are sampled as plain inputs.
 */
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module bdp_dimming_core
    import bdp_pkg::*;
#(
    parameter int LVL_W = 10,
    parameter int LAMP_OUT_CYCLES = LAMP_OUT_CYC,
    parameter int INT_TICK_CYCLES = INT_TICK_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire bdp_axil_req_s axi_req,
    output bdp_axil_rsp_s axi_rsp,
    input wire bdp_mode_e mode_level,
    input wire logic mode_clk,
    input wire logic [LVL_W-1:0] analog_level_input,
    input wire logic [LVL_W-1:0] analog_level_reference,
    input wire logic [LVL_W-1:0] min_level_input,
    input wire logic min_at_rail,
    input wire logic shutdown_pin,
    input wire logic uvlo,
    input wire logic lamp_current_sense,
    input wire logic buck_sync_pin,
    input wire logic pwm_cmp_trip,
    input wire logic current_limit,
    input wire logic ccv_low,
    output logic [4:0] brightness_code,
    output logic [LVL_W-1:0] current_target,
    output logic chopping_pwm,
    output logic current_reg_en,
    output logic buck_gate,
    output logic lamp_drive_en,
    output logic lamp_fault_flag,
    output logic short_fault,
    output logic shutdown_active
);
    localparam int LCW = $clog2(LAMP_OUT_CYCLES + 1);
    localparam int TCW = $clog2(INT_TICK_CYCLES + 1);
    localparam int SCW = $clog2(SYNC_LOSS_CYC + 1);
    localparam int GCW = $clog2(GLITCH_CYC + 1);
    localparam int OCW = $clog2(MIN_OFF_CYC + 1);
    localparam int PW = LVL_W + 6;

    logic sd_reg_ff;
    logic [4:0] bright_reg_ff;
    logic [4:0] adc_code_ff;
    logic [4:0] code_ff;
    logic [PW-1:0] cur_ff;
    logic lamp_out_ff;
    logic short_ff;
    logic [LCW-1:0] lamp_cnt_ff;
    logic [GCW-1:0] glitch_cnt_ff;
    logic mode_clk_q_ff;
    logic [SCW-1:0] sync_age_ff;
    logic [TCW-1:0] int_div_ff;
    logic [6:0] per_cnt_ff;
    logic [6:0] short_cnt_ff;
    logic chop_ff;
    logic buck_sync_q_ff;
    bdp_buck_e buck_st_ff;
    bdp_buck_e nxt_buck_st;
    logic [OCW-1:0] off_cnt_ff;

    logic serial_mode;
    logic sd;
    logic run;
    logic ext_lock;
    logic tick;
    logic period_end;
    logic [7:0] on_cnt;
    logic chop_now;
    logic sense_ok;
    logic [PW-1:0] lvl33;
    logic [PW-1:0] thr_up;
    logic [PW-1:0] thr_dn;
    logic [LVL_W-1:0] min_eff;
    logic [PW-1:0] cur_sum;

    // Mode at the supply rail hands the pins to the serial bus
    assign serial_mode = (mode_level == MODE_RAIL);
    assign sd = shutdown_pin | (serial_mode & sd_reg_ff);
    assign run = ~sd & ~lamp_out_ff & ~short_ff;

    // Level converter with one code of hysteresis
    assign lvl33 = PW'(analog_level_input) * PW'(ADC_DIV);
    always_comb begin
        if (mode_level == MODE_REF) begin
            thr_up = PW'(ADC_DIV - {1'b0, adc_code_ff}) * PW'(analog_level_reference);
            thr_dn = PW'(6'(CODE_MAX) - {1'b0, adc_code_ff}) * PW'(analog_level_reference);
        end else begin
            thr_up = PW'({1'b0, adc_code_ff} + 6'h02) * PW'(analog_level_reference);
            thr_dn = PW'(adc_code_ff) * PW'(analog_level_reference);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adc_code_ff <= 5'h00;
        end else if (!sd && !serial_mode) begin
            if (mode_level == MODE_REF) begin
                if (adc_code_ff != 5'h00 && lvl33 >= thr_up) begin
                    adc_code_ff <= adc_code_ff - 5'h01;
                end else if (adc_code_ff != CODE_MAX && lvl33 < thr_dn) begin
                    adc_code_ff <= adc_code_ff + 5'h01;
                end
            end else begin
                if (adc_code_ff != CODE_MAX && lvl33 >= thr_up) begin
                    adc_code_ff <= adc_code_ff + 5'h01;
                end else if (adc_code_ff != 5'h00 && lvl33 < thr_dn) begin
                    adc_code_ff <= adc_code_ff - 5'h01;
                end
            end
        end
    end

    // Code source follows the interface mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_ff <= 5'h00;
        end else begin
            code_ff <= serial_mode ? bright_reg_ff : adc_code_ff;
        end
    end

    // Current target; a rail-tied minimum counts as zero
    assign min_eff = min_at_rail ? '0 : min_level_input;
    assign cur_sum = PW'(analog_level_reference) * PW'(code_ff)
                   + PW'(min_eff) * PW'(CODE_SPAN - {1'b0, code_ff});

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= cur_sum / PW'(CUR_DIV);
        end
    end

    // Sync detection: edges seen recently mean the mode pin carries a clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_clk_q_ff <= 1'b0;
            sync_age_ff <= SCW'(SYNC_LOSS_CYC);
        end else begin
            mode_clk_q_ff <= mode_clk;
            if (mode_clk && !mode_clk_q_ff) begin
                sync_age_ff <= '0;
            end else if (sync_age_ff != SCW'(SYNC_LOSS_CYC)) begin
                sync_age_ff <= sync_age_ff + SCW'(1);
            end
        end
    end
    assign ext_lock = (sync_age_ff != SCW'(SYNC_LOSS_CYC));

    // Free-running tick when no external clock is present
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_div_ff <= '0;
        end else if (int_div_ff == TCW'(INT_TICK_CYCLES - 1)) begin
            int_div_ff <= '0;
        end else begin
            int_div_ff <= int_div_ff + TCW'(1);
        end
    end

    assign tick = ext_lock ? (mode_clk & ~mode_clk_q_ff)
                           : (int_div_ff == TCW'(INT_TICK_CYCLES - 1));
    assign period_end = tick && (per_cnt_ff == 7'(TICKS_PER_PERIOD - 1));

    // Period counter holds at zero in shutdown so each wake starts a fresh period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            per_cnt_ff <= 7'h00;
        end else if (sd) begin
            per_cnt_ff <= 7'h00;
        end else if (tick) begin
            per_cnt_ff <= per_cnt_ff + 7'h01;
        end
    end

    // On-count: four ticks per code, low codes floored
    assign on_cnt = (code_ff <= DUTY_FLOOR_CODE) ? DUTY_MIN_ON
                  : {1'b0, code_ff, 2'h0} + 8'h04;
    assign chop_now = min_at_rail | ({1'b0, per_cnt_ff} < on_cnt);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chop_ff <= 1'b0;
        end else begin
            chop_ff <= run & chop_now;
        end
    end

    // Glitch filter: sense must stay high for the full window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            glitch_cnt_ff <= '0;
        end else if (!lamp_current_sense) begin
            glitch_cnt_ff <= '0;
        end else if (glitch_cnt_ff != GCW'(GLITCH_CYC)) begin
            glitch_cnt_ff <= glitch_cnt_ff + GCW'(1);
        end
    end
    assign sense_ok = lamp_current_sense && (glitch_cnt_ff >= GCW'(GLITCH_CYC - 1));

    // Lamp-out timer; runs only while the lamp is driven
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lamp_cnt_ff <= '0;
            lamp_out_ff <= 1'b0;
        end else if (sd) begin
            lamp_cnt_ff <= '0;
            lamp_out_ff <= 1'b0;
        end else if (!lamp_out_ff && !short_ff) begin
            if (sense_ok) begin
                lamp_cnt_ff <= '0;
            end else if (lamp_cnt_ff == LCW'(LAMP_OUT_CYCLES - 1)) begin
                lamp_out_ff <= 1'b1;
            end else begin
                lamp_cnt_ff <= lamp_cnt_ff + LCW'(1);
            end
        end
    end

    // Buck short: error amp low at the end of consecutive periods
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            short_cnt_ff <= 7'h00;
            short_ff <= 1'b0;
        end else if (sd) begin
            short_cnt_ff <= 7'h00;
            short_ff <= 1'b0;
        end else if (run && period_end) begin
            if (!ccv_low) begin
                short_cnt_ff <= 7'h00;
            end else if (short_cnt_ff == 7'(SHORT_PERIODS - 1)) begin
                short_ff <= 1'b1;
            end else begin
                short_cnt_ff <= short_cnt_ff + 7'h01;
            end
        end
    end

    // Buck switch timing
    always_comb begin
        nxt_buck_st = buck_st_ff;
        case (buck_st_ff)
            BK_OFF: begin
                if (off_cnt_ff >= OCW'(MIN_OFF_CYC - 1)) begin
                    nxt_buck_st = BK_READY;
                end
            end
            BK_READY: begin
                if (!buck_sync_pin && buck_sync_q_ff && chop_ff && !uvlo) begin
                    nxt_buck_st = BK_ON;
                end
            end
            BK_ON: begin
                if (pwm_cmp_trip || current_limit || !chop_ff || uvlo) begin
                    nxt_buck_st = BK_OFF;
                end
            end
            default: nxt_buck_st = BK_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buck_st_ff <= BK_OFF;
            buck_sync_q_ff <= 1'b0;
            off_cnt_ff <= '0;
        end else begin
            buck_st_ff <= nxt_buck_st;
            buck_sync_q_ff <= buck_sync_pin;
            if (nxt_buck_st == BK_ON) begin
                off_cnt_ff <= '0;
            end else if (off_cnt_ff != OCW'(MIN_OFF_CYC)) begin
                off_cnt_ff <= off_cnt_ff + OCW'(1);
            end
        end
    end

    // AXI4-Lite slave; write address and data may arrive in either order
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [AXI_AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic awready;
    logic wready;
    logic arready;
    logic wr_go;
    logic [31:0] status_word;

    assign awready = ~aw_hold_ff & ~bvalid_ff;
    assign wready = ~w_hold_ff & ~bvalid_ff;
    assign arready = ~rvalid_ff;
    assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb0_ff <= 1'b0;
        end else begin
            if (axi_req.awvalid && awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= axi_req.awaddr;
            end else if (wr_go) begin
                aw_hold_ff <= 1'b0;
            end
            if (axi_req.wvalid && wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= axi_req.wdata;
                wstrb0_ff <= axi_req.wstrb[0];
            end else if (wr_go) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    // Registers keep their contents through shutdown; only reset clears them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sd_reg_ff <= 1'b0;
            bright_reg_ff <= 5'h00;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= RESP_OKAY;
            case (awaddr_ff)
                REG_CTRL: begin
                    if (wstrb0_ff) begin
                        sd_reg_ff <= wdata_ff[CTRL_SD_BIT];
                    end
                end
                REG_BRIGHT: begin
                    if (wstrb0_ff) begin
                        bright_reg_ff <= wdata_ff[4:0];
                    end
                end
                REG_STATUS: bresp_ff <= RESP_OKAY;
                default: bresp_ff <= RESP_SLVERR;
            endcase
        end else if (bvalid_ff && axi_req.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_CODE_LSB +: 5] = code_ff;
        status_word[ST_FAULT_BIT] = lamp_out_ff | short_ff;
        status_word[ST_SHORT_BIT] = short_ff;
        status_word[ST_CHOP_BIT] = chop_ff;
        status_word[ST_SYNC_BIT] = ext_lock;
        status_word[ST_SD_BIT] = sd;
        status_word[ST_LAMP_BIT] = lamp_out_ff;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (axi_req.arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (axi_req.araddr)
                REG_CTRL: rdata_ff <= {31'h0000_0000, sd_reg_ff};
                REG_BRIGHT: rdata_ff <= {27'h000_0000, bright_reg_ff};
                REG_STATUS: rdata_ff <= status_word;
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && axi_req.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    always_comb begin
        axi_rsp.awready = awready;
        axi_rsp.wready = wready;
        axi_rsp.bvalid = bvalid_ff;
        axi_rsp.bresp = bresp_ff;
        axi_rsp.arready = arready;
        axi_rsp.rvalid = rvalid_ff;
        axi_rsp.rdata = rdata_ff;
        axi_rsp.rresp = rresp_ff;
    end

    assign brightness_code = code_ff;
    assign current_target = cur_ff[LVL_W-1:0];
    assign chopping_pwm = chop_ff;
    assign current_reg_en = chop_ff;
    assign buck_gate = (buck_st_ff == BK_ON);
    assign lamp_drive_en = run;
    assign lamp_fault_flag = lamp_out_ff | short_ff;
    assign short_fault = short_ff;
    assign shutdown_active = sd;
endmodule : bdp_dimming_core

// *** src/bdp_pkg.sv ***
/*
 * Shared constants, types and register map of the backlight dimming core.
 * Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
package bdp_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_PS = 10_000;
    localparam int MIN_OFF_NS = 375;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GLITCH_NS = 200;
    localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LAMP_OUT_S = 2;
    localparam int LAMP_OUT_CYC = LAMP_OUT_S * CLK_HZ;
    localparam int SYNC_MIN_HZ = 32_000;
    localparam int SYNC_LOSS_CYC = CLK_HZ / SYNC_MIN_HZ * 5 / 4;
    localparam int INT_TICK_CYC = 2000;
    localparam int TICKS_PER_PERIOD = 128;
    localparam int SHORT_PERIODS = 64;

    localparam logic [4:0] CODE_MAX = 5'h1F;
    localparam logic [5:0] CODE_SPAN = 6'h20;
    localparam logic [5:0] ADC_DIV = 6'h21;
    localparam int CUR_DIV = 320;
    localparam logic [4:0] DUTY_FLOOR_CODE = 5'h03;
    localparam logic [7:0] DUTY_MIN_ON = 8'h0C;

    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_BRIGHT = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam int CTRL_SD_BIT = 0;
    localparam int ST_CODE_LSB = 0;
    localparam int ST_FAULT_BIT = 8;
    localparam int ST_SHORT_BIT = 9;
    localparam int ST_CHOP_BIT = 10;
    localparam int ST_SYNC_BIT = 11;
    localparam int ST_SD_BIT = 12;
    localparam int ST_LAMP_BIT = 13;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_GND, MODE_REF, MODE_RAIL} bdp_mode_e;
    typedef enum logic [1:0] {BK_OFF, BK_READY, BK_ON} bdp_buck_e;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } bdp_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bdp_axil_rsp_s;
endpackage : bdp_pkg

// *** verification/bdp_dimming_chk.sv ***
/* Port checker of the dimming core: buck timing, shutdown, faults, target.
   Bound to every bdp_dimming_core; sees its ports only. */
`timescale 1ns/1ps
module bdp_dimming_chk
    import bdp_pkg::*;
#(
    parameter int LVL_W = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [LVL_W-1:0] analog_level_reference,
    input wire logic [LVL_W-1:0] min_level_input,
    input wire logic min_at_rail,
    input wire logic uvlo,
    input wire logic buck_sync_pin,
    input wire logic pwm_cmp_trip,
    input wire logic current_limit,
    input wire logic [4:0] brightness_code,
    input wire logic [LVL_W-1:0] current_target,
    input wire logic chopping_pwm,
    input wire logic current_reg_en,
    input wire logic buck_gate,
    input wire logic lamp_drive_en,
    input wire logic lamp_fault_flag,
    input wire logic short_fault,
    input wire logic shutdown_active
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [5:0] off_cnt_ff;
    int tgt_exp;
    // Saturates so a long idle never wraps below the minimum off time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            off_cnt_ff <= 6'h00;
        end else if (buck_gate) begin
            off_cnt_ff <= 6'h00;
        end else if (off_cnt_ff != 6'h3F) begin
            off_cnt_ff <= off_cnt_ff + 6'h01;
        end
    end
    always_comb begin
        tgt_exp = (int'(analog_level_reference) * int'(brightness_code)
            + (min_at_rail ? 0 : int'(min_level_input)) * (32 - int'(brightness_code))) / 320;
    end
    sequence run_end_s;
        buck_gate && (pwm_cmp_trip || current_limit);
    endsequence
    sequence steady_s;
        !shutdown_active && $stable(brightness_code) && $stable(analog_level_reference)
            && $stable(min_level_input) && $stable(min_at_rail);
    endsequence
    min_off_a: assert property ($rose(buck_gate) |-> off_cnt_ff >= MIN_OFF_CYC)
        else $error("buck on before minimum off time");
    sync_start_a: assert property ($rose(buck_gate) |-> !$past(buck_sync_pin) && !$past(uvlo))
        else $error("buck on without sync fall");
    on_end_a: assert property (run_end_s |-> ##[1:2] !buck_gate)
        else $error("buck on phase not ended");
    uvlo_off_a: assert property (uvlo [*2] |-> !buck_gate)
        else $error("buck on in undervoltage");
    sd_latch_a: assert property (shutdown_active [*2] |-> !lamp_fault_flag && !short_fault)
        else $error("fault latch kept in shutdown");
    sd_drive_a: assert property (shutdown_active |-> !lamp_drive_en)
        else $error("lamp driven in shutdown");
    fault_drive_a: assert property (lamp_fault_flag |-> !lamp_drive_en ##1 !chopping_pwm)
        else $error("lamp driven after fault");
    reg_window_a: assert property (current_reg_en == chopping_pwm)
        else $error("regulation outside on time");
    target_a: assert property (steady_s [*3] |-> current_target == tgt_exp[LVL_W-1:0])
        else $error("current target wrong");
endmodule : bdp_dimming_chk

bind bdp_dimming_core bdp_dimming_chk #(.LVL_W(LVL_W)) i_bdp_dimming_chk (.clk(clk), .nrst(nrst),
    .analog_level_reference(analog_level_reference), .min_level_input(min_level_input),
    .min_at_rail(min_at_rail), .uvlo(uvlo), .buck_sync_pin(buck_sync_pin), .pwm_cmp_trip(pwm_cmp_trip),
    .current_limit(current_limit), .brightness_code(brightness_code), .current_target(current_target),
    .chopping_pwm(chopping_pwm), .current_reg_en(current_reg_en), .buck_gate(buck_gate),
    .lamp_drive_en(lamp_drive_en), .lamp_fault_flag(lamp_fault_flag), .short_fault(short_fault),
    .shutdown_active(shutdown_active));

// *** verification/bdp_stage_model.sv ***
/* Inverter stage and lamp model: zero-cross sync, ramp trip, lamp sense.
   A dead lamp shows only short sense glitches, never real current. */
`timescale 1ns/1ps
module bdp_stage_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic buck_gate,
    input wire logic chopping_pwm,
    input wire logic lamp_drive_en,
    input wire logic lamp_alive,
    output logic lamp_current_sense,
    output logic buck_sync_pin,
    output logic pwm_cmp_trip
);
    logic [5:0] ph_ff;
    logic [3:0] on_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_ff <= 6'h00;
        end else begin
            ph_ff <= ph_ff + 6'h01;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            on_ff <= 4'h0;
        end else begin
            on_ff <= buck_gate ? on_ff + 4'h1 : 4'h0;
        end
    end
    assign buck_sync_pin = !ph_ff[4];
    assign pwm_cmp_trip = buck_gate && (on_ff >= 4'h6);
    // Glitches of 8 cycles, well under the 20-cycle qualification
    assign lamp_current_sense = lamp_alive ? (lamp_drive_en && chopping_pwm) : (ph_ff[5:3] == 3'h0);
endmodule : bdp_stage_model

// *** verification/bdp_dimming_core_tb.sv ***
/* Self-checking bench of the dimming core.
   Needs bdp_pkg, the checker and the stage model. */
`timescale 1ns/1ps
module bdp_dimming_core_tb
    import bdp_pkg::*;
;
    localparam int TK = 4;
    logic clk = 0, nrst = 0, mclk = 0, sync_on = 0, rail = 0, sd = 0, uv = 0, alive = 1, lim = 0;
    bdp_axil_req_s req = '0;
    bdp_axil_rsp_s rsp;
    bdp_mode_e mode = MODE_RAIL;
    logic [9:0] lvl = 10'h000, mn = 10'h000, tgt;
    logic [4:0] code;
    logic chop, creg, gate, drv, flt, sft, sda, sense, sync, trip;
    int err_total = 0, checked = 0;
    logic [65:0] rq[$];
    logic [1:0] wq[$];
    bdp_dimming_core #(.LVL_W(10), .LAMP_OUT_CYCLES(2000), .INT_TICK_CYCLES(TK)) i_bdp_dimming_core (
        .clk(clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp), .mode_level(mode), .mode_clk(mclk),
        .analog_level_input(lvl), .analog_level_reference(10'h14A), .min_level_input(mn),
        .min_at_rail(rail), .shutdown_pin(sd), .uvlo(uv), .lamp_current_sense(sense),
        .buck_sync_pin(sync), .pwm_cmp_trip(trip), .current_limit(lim), .ccv_low(1'b0),
        .brightness_code(code), .current_target(tgt), .chopping_pwm(chop), .current_reg_en(creg),
        .buck_gate(gate), .lamp_drive_en(drv), .lamp_fault_flag(flt), .short_fault(sft),
        .shutdown_active(sda));
    bdp_stage_model i_bdp_stage_model (.clk(clk), .nrst(nrst), .buck_gate(gate), .chopping_pwm(chop),
        .lamp_drive_en(drv), .lamp_alive(alive), .lamp_current_sense(sense), .buck_sync_pin(sync),
        .pwm_cmp_trip(trip));
    always #5 clk = !clk;
    // Sync at 5 MHz keeps the run short; the period still spans 128 pulses
    always #100 mclk = sync_on ? !mclk : 1'b0;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    always @(posedge clk) begin : mon
        logic [65:0] e;
        if (rsp.rvalid && req.rready && rq.size() > 0) begin
            e = rq.pop_front();
            chk(rsp.rdata & e[65:34], e[33:2]);
            chk(rsp.rresp, e[1:0]);
        end
        if (rsp.bvalid && req.bready && wq.size() > 0) begin
            chk(rsp.bresp, wq.pop_front());
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                break;
            end
        end
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({m, d, r});
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                req.rready <= 1'b0;
                break;
            end
        end
        @(posedge clk);
    endtask : rd
    task automatic duty(input int exp_hi, input int per);
        int n;
        n = 0;
        repeat (per + 8) @(posedge clk);
        repeat (per) begin
            @(posedge clk);
            n += int'(chop);
        end
        chk(n, exp_hi);
    endtask : duty
    function automatic int settle(input int n, input int v, input bit neg);
        repeat (40) begin
            if (!neg && n < 31 && 33 * v >= (n + 2) * 330) n++;
            else if (!neg && n > 0 && 33 * v < n * 330) n--;
            else if (neg && n > 0 && 33 * v >= (33 - n) * 330) n--;
            else if (neg && n < 31 && 33 * v < (31 - n) * 330) n++;
        end
        return n;
    endfunction : settle
    task automatic results();
        $display("errors=%0d checks=%0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        $display("[ERR] t=%0t timeout", $time);
        results();
    end
    initial begin
        int cl[6] = '{0, 3, 4, 16, 30, 31};
        int cur;
        void'($urandom(32'h2577));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(REG_CTRL, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
        rd(8'h0C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'h1, RESP_SLVERR);
        foreach (cl[i]) begin
            wr(REG_BRIGHT, cl[i], RESP_OKAY);
            rd(REG_STATUS, 32'h1F, cl[i], RESP_OKAY);
            duty((cl[i] > 3 ? 4 * cl[i] + 4 : 12) * TK, 128 * TK);
        end
        wr(REG_BRIGHT, 32'h0, RESP_OKAY);
        rail <= 1'b1;
        duty(128 * TK, 128 * TK);
        rail <= 1'b0;
        wr(REG_BRIGHT, 32'hF, RESP_OKAY);
        sync_on = 1'b1;
        duty(64 * 20, 128 * 20);
        rd(REG_STATUS, 32'h800, 32'h800, RESP_OKAY);
        sync_on = 1'b0;
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        rd(REG_STATUS, 32'h101F, 32'h100F, RESP_OKAY);
        chk(drv, 1'b0);
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        uv <= 1'b1;
        repeat (600) @(posedge clk);
        uv <= 1'b0;
        mode <= MODE_GND;
        cur = 0;
        for (int i = 0; i < 10; i++) begin
            if (i == 5) mode <= MODE_REF;
            lim <= i[0];
            lvl <= (i % 5 == 0) ? 10'h000 : 10'(($urandom % 33) * 10 + 5);
            mn <= 10'($urandom % 331);
            repeat (40) @(posedge clk);
            cur = settle(cur, int'(lvl), i >= 5);
            chk(code, cur);
            chk(tgt, (330 * cur + int'(mn) * (32 - cur)) / 320);
        end
        wr(REG_BRIGHT, 32'h1F, RESP_OKAY);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        rd(REG_STATUS, 32'h101F, cur, RESP_OKAY);
        while (!chop) @(posedge clk);
        repeat (25) @(posedge clk);
        alive <= 1'b0;
        repeat (1900) @(posedge clk);
        chk(flt, 1'b0);
        repeat (200) @(posedge clk);
        chk(flt, 1'b1);
        chk(drv, 1'b0);
        rd(REG_STATUS, 32'h2100, 32'h2100, RESP_OKAY);
        sd <= 1'b1;
        alive <= 1'b1;
        repeat (3) @(posedge clk);
        chk(flt, 1'b0);
        rd(REG_STATUS, 32'h3100, 32'h1000, RESP_OKAY);
        sd <= 1'b0;
        repeat (3) @(posedge clk);
        chk(drv, 1'b1);
        results();
    end
endmodule : bdp_dimming_core_tb
